// file: efa_pkg.sv
// Constants, types and size arithmetic for the packet buffer allocator.
package efa_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_NS = 100;
  localparam int SOFTWARE_RESET_TIMEOUT_FLAG_NS = 10000;
  localparam int SOFTWARE_RESET_TIMEOUT_FLAG_CYC = (SOFTWARE_RESET_TIMEOUT_FLAG_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------
  // Register offsets and fields
  // ----------------------------------------
  localparam logic [7:0] HWCFG_OFS = 8'h74;
  localparam logic [7:0] RXCTL_OFS = 8'h78;
  localparam logic [7:0] ALLOC_OFS = 8'h90;
  localparam logic [7:0] RXSTS_OFS = 8'h94;
  localparam logic [7:0] DROP_OFS = 8'h98;
  localparam logic [7:0] ERR_OFS = 8'h9c;
  localparam int HW_KEEP_LO = 28;
  localparam int HW_MBO = 20;
  localparam int HW_SZ_LO = 16;
  localparam int HW_TO = 1;
  localparam int HW_SOFTWARE_RESET_TRIGGER = 0;
  localparam int RX_SKIP = 31;
  localparam logic [1:0] KEEP_RST = 2'h0;
  localparam logic [3:0] TX_SZ_RST = 4'h5;
  localparam logic [3:0] TX_SZ_MIN = 4'h2;
  localparam logic [3:0] TX_SZ_MAX = 4'he;

  // ----------------------------------------
  // Memory split and side buffers
  // ----------------------------------------
  localparam int KB_BYTES = 1024;
  localparam int MEM_BYTES = 16384;
  localparam int TXS_BYTES = 512;
  localparam int TXS_WORDS = 128;
  localparam int RXS_DIV = 16;
  localparam int RXD_FULL_MARGIN = 4;
  localparam int MIL_TX_BYTES = 2048;
  localparam int MIL_TX_WORDS = MIL_TX_BYTES / 4;
  localparam int MIL_TX_FRAMES = 2;
  localparam int MIL_RX_BYTES = 128;
  localparam int MIL_RX_WORDS = MIL_RX_BYTES / 4;
  localparam int MIL_RX_AW = 5;
  localparam int MIL_RX_DW = 33;

  typedef enum logic [1:0] {SR_IDLE, SR_WAIT, SR_GO} efa_sr_t;

  // Reserved encodings are clamped so the split never underflows.
  function automatic logic [15:0] efa_tx_total(input logic [3:0] sz);
    logic [3:0] c;
    c = (sz < TX_SZ_MIN) ? TX_SZ_MIN : (sz > TX_SZ_MAX) ? TX_SZ_MAX : sz;
    return 16'(int'(c) * KB_BYTES);
  endfunction : efa_tx_total

  function automatic logic [15:0] efa_rx_total(input logic [3:0] sz);
    return 16'(MEM_BYTES - int'(efa_tx_total(sz)));
  endfunction : efa_rx_total

  function automatic logic [15:0] efa_rx_status(input logic [3:0] sz);
    return 16'(int'(efa_rx_total(sz)) / RXS_DIV);
  endfunction : efa_rx_status

endpackage : efa_pkg

// file: efa_mem_if.sv
// Port bundle between the allocator and its receive side-buffer memory.
interface efa_mem_if;
  import efa_pkg::*;
  logic we;
  logic [MIL_RX_AW-1:0] waddr;
  logic [MIL_RX_DW-1:0] wdata;
  logic [MIL_RX_AW-1:0] raddr;
  logic [MIL_RX_DW-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport ram (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : efa_mem_if

// file: efa_mil_ram.sv
// Receive side-buffer memory with registered read data.
module efa_mil_ram
  import efa_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Memory port
  efa_mem_if.ram m
);

  logic [MIL_RX_DW-1:0] mem [MIL_RX_WORDS];

  always_ff @(posedge mclk) begin
    if (m.we) begin
      mem[m.waddr] <= m.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    m.rdata <= mem[m.raddr];
  end

endmodule : efa_mil_ram

// file: efa_alloc.sv
// Packet buffer allocator with side buffers, frame skip and software reset.
//
// Chosen here: the plain strobed port.
module efa_alloc
  import efa_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // PHY and MAC status
  input wire logic phy_clk_ok,
  input wire logic mac_tx_err,
  input wire logic mac_rx_err,
  output logic mac_csr_reset,
  // MAC receive stream
  input wire logic mac_rx_valid,
  input wire logic [31:0] mac_rx_data,
  input wire logic mac_rx_last,
  // Receive data memory side
  output logic rxd_push,
  output logic [31:0] rxd_wdata,
  output logic rxd_wlast,
  input wire logic rxd_drain,
  input wire logic rxd_drain_last,
  output logic rxd_skip,
  // Transmit path
  input wire logic txd_valid,
  input wire logic txd_last,
  output logic txd_pop,
  input wire logic mac_tx_rd,
  input wire logic mac_tx_rd_last,
  output logic mil_tx_avail,
  // Configuration outputs
  output logic [15:0] tx_data_bytes,
  output logic [15:0] rx_data_bytes,
  output logic [15:0] rx_status_bytes,
  output logic [1:0] keep_bits
);

  efa_mem_if mem ();

  efa_mil_ram u_ram (
    .mclk(mclk),
    .m(mem.ram)
  );

  logic ok_s1_ff, ok_s2_ff, armed_ff, skip_ff, to_ff, mbo_ff;
  logic [3:0] sz_ff;
  logic [1:0] keep_ff, err_ff;
  logic [15:0] drop_ff;
  efa_sr_t sr_ff;
  logic [7:0] tmr_ff;
  logic [MIL_RX_AW:0] rcnt_ff;
  logic [MIL_RX_AW-1:0] wptr_ff, rptr_ff;
  logic in_frm_ff, disc_ff, ovr_ff;
  logic [15:0] used_ff;
  logic [9:0] txw_ff;
  logic [1:0] txf_ff;
  logic [31:0] rdata_ff;
  logic wr_ok, software_reset_trigger_go, rxd_full, sof, start_disc, mil_full, acc, overrun, rd_go, tpop;
  logic [15:0] thr;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // write gate
  assign wr_ok = reg_wr && armed_ff;
  assign software_reset_trigger_go = (sr_ff == SR_GO);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ok_s1_ff <= 1'b0;
      ok_s2_ff <= 1'b0;
    end else begin
      ok_s1_ff <= phy_clk_ok;
      ok_s2_ff <= ok_s1_ff;
    end
  end

  // A soft reset counts as a reset, so the host must read again first.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      armed_ff <= 1'b0;
    end else if (software_reset_trigger_go) begin
      armed_ff <= 1'b0;
    end else if (reg_rd) begin
      armed_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      keep_ff <= KEEP_RST;
      sz_ff <= TX_SZ_RST;
      mbo_ff <= 1'b0;
    end else if (software_reset_trigger_go) begin
      sz_ff <= TX_SZ_RST;
      mbo_ff <= 1'b0;
    end else if (wr_ok && reg_addr == HWCFG_OFS) begin
      keep_ff <= reg_wdata[HW_KEEP_LO+:2];
      sz_ff <= reg_wdata[HW_SZ_LO+:4];
      mbo_ff <= reg_wdata[HW_MBO];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sr_ff <= SR_IDLE;
      tmr_ff <= 8'h00;
      to_ff <= 1'b0;
    end else begin
      case (sr_ff)
        SR_IDLE: begin
          tmr_ff <= 8'h00;
          if (wr_ok && reg_addr == HWCFG_OFS && reg_wdata[HW_SOFTWARE_RESET_TRIGGER]) begin
            sr_ff <= SR_WAIT;
          end
        end
        SR_WAIT: begin
          tmr_ff <= tmr_ff + 8'h01;
          if (ok_s2_ff) begin
            sr_ff <= SR_GO;
          end else if (tmr_ff == 8'(SOFTWARE_RESET_TIMEOUT_FLAG_CYC - 1)) begin
            to_ff <= 1'b1;
            sr_ff <= SR_IDLE;
          end
        end
        SR_GO: begin
          to_ff <= 1'b0;
          sr_ff <= SR_IDLE;
        end
        default: sr_ff <= SR_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mac_csr_reset <= 1'b0;
    end else begin
      mac_csr_reset <= software_reset_trigger_go;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      err_ff <= 2'h0;
    end else if (software_reset_trigger_go) begin
      err_ff <= 2'h0;
    end else begin
      err_ff <= err_ff | {mac_rx_err, mac_tx_err};
    end
  end

  // skip held until frame end drained
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      skip_ff <= 1'b0;
    end else if (software_reset_trigger_go) begin
      skip_ff <= 1'b0;
    end else if (wr_ok && reg_addr == RXCTL_OFS && reg_wdata[RX_SKIP]) begin
      // A new request in the cycle the old skip ends wins, so it is never lost.
      skip_ff <= 1'b1;
    end else if (skip_ff && rxd_drain && rxd_drain_last) begin
      skip_ff <= 1'b0;
    end
  end

  // side buffer levels have no register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h0;
    end else if (!reg_rd) begin
      rdata_ff <= 32'h0;
    end else begin
      case (reg_addr)
        HWCFG_OFS: rdata_ff <= {2'h0, keep_ff, 7'h0, mbo_ff, sz_ff, 14'h0, to_ff, sr_ff != SR_IDLE};
        RXCTL_OFS: rdata_ff <= {skip_ff, 31'h0};
        ALLOC_OFS: rdata_ff <= {rx_data_bytes, tx_data_bytes};
        RXSTS_OFS: rdata_ff <= {16'h0, rx_status_bytes};
        DROP_OFS: rdata_ff <= {16'h0, drop_ff};
        ERR_OFS: rdata_ff <= {30'h0, err_ff};
        default: rdata_ff <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Memory split
  // ----------------------------------------
  // size sets totals
  // status fixed, data the rest; receive split
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_data_bytes <= 16'h0;
      rx_data_bytes <= 16'h0;
      rx_status_bytes <= 16'h0;
    end else begin
      tx_data_bytes <= 16'(int'(efa_tx_total(sz_ff)) - TXS_BYTES);
      rx_data_bytes <= efa_rx_total(sz_ff) - efa_rx_status(sz_ff);
      rx_status_bytes <= efa_rx_status(sz_ff);
    end
  end

  assign thr = 16'(int'(rx_data_bytes >> 2) - RXD_FULL_MARGIN);
  assign rxd_full = (used_ff >= thr);

  // ----------------------------------------
  // Receive side buffer
  // ----------------------------------------
  assign sof = mac_rx_valid && !in_frm_ff;
  assign start_disc = sof && ovr_ff && rxd_full;
  assign mil_full = (rcnt_ff == (MIL_RX_AW+1)'(MIL_RX_WORDS));
  assign acc = mac_rx_valid && !disc_ff && !start_disc && !mil_full;
  assign overrun = mac_rx_valid && !disc_ff && !start_disc && mil_full;
  assign rd_go = (rcnt_ff != '0) && !rxd_full;

  assign mem.we = acc;
  assign mem.waddr = wptr_ff;
  assign mem.wdata = {mac_rx_last, mac_rx_data};
  assign mem.raddr = rptr_ff;
  assign rxd_wdata = mem.rdata[31:0];
  assign rxd_wlast = mem.rdata[32];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      rcnt_ff <= '0;
      rxd_push <= 1'b0;
    end else if (software_reset_trigger_go) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      rcnt_ff <= '0;
      rxd_push <= 1'b0;
    end else begin
      wptr_ff <= wptr_ff + MIL_RX_AW'(acc);
      rptr_ff <= rptr_ff + MIL_RX_AW'(rd_go);
      rcnt_ff <= rcnt_ff + (MIL_RX_AW+1)'(acc) - (MIL_RX_AW+1)'(rd_go);
      rxd_push <= rd_go;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_frm_ff <= 1'b0;
      disc_ff <= 1'b0;
      ovr_ff <= 1'b0;
      drop_ff <= 16'h0;
    end else if (software_reset_trigger_go) begin
      in_frm_ff <= 1'b0;
      disc_ff <= 1'b0;
      ovr_ff <= 1'b0;
      drop_ff <= 16'h0;
    end else begin
      if (mac_rx_valid) begin
        in_frm_ff <= !mac_rx_last;
        disc_ff <= !mac_rx_last && (disc_ff || overrun || start_disc);
      end
      if (overrun) begin
        ovr_ff <= 1'b1;
      end else if (sof && !rxd_full) begin
        ovr_ff <= 1'b0;
      end
      if (overrun || start_disc) begin
        drop_ff <= drop_ff + 16'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      used_ff <= 16'h0;
    end else if (software_reset_trigger_go) begin
      used_ff <= 16'h0;
    end else begin
      used_ff <= used_ff + 16'(rd_go) - 16'(rxd_drain);
    end
  end

  // ----------------------------------------
  // Transmit side buffer
  // ----------------------------------------
  // commands and payload alike
  // refill as space frees, two frames max
  assign tpop = txd_valid && !txd_pop && (txw_ff < 10'(MIL_TX_WORDS)) && (txf_ff < 2'(MIL_TX_FRAMES));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txd_pop <= 1'b0;
      txw_ff <= 10'h0;
      txf_ff <= 2'h0;
      mil_tx_avail <= 1'b0;
    end else if (software_reset_trigger_go) begin
      txd_pop <= 1'b0;
      txw_ff <= 10'h0;
      txf_ff <= 2'h0;
      mil_tx_avail <= 1'b0;
    end else begin
      txd_pop <= tpop;
      txw_ff <= txw_ff + 10'(tpop) - 10'(mac_tx_rd);
      txf_ff <= txf_ff + 2'(tpop && txd_last) - 2'(mac_tx_rd && mac_tx_rd_last);
      mil_tx_avail <= (txw_ff + 10'(tpop) - 10'(mac_tx_rd)) != 10'h0;
    end
  end

  assign reg_rdata = rdata_ff;
  assign rxd_skip = skip_ff;
  assign keep_bits = keep_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  property p_wr_gate;
    !armed_ff && reg_wr |=> $stable(sz_ff) && sr_ff == SR_IDLE;
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write acted before first read");

  property p_software_reset_trigger_clr;
    software_reset_trigger_go |=> err_ff == 2'h0 && drop_ff == 16'h0 && sz_ff == TX_SZ_RST && mac_csr_reset && !armed_ff;
  endproperty
  a_software_reset_trigger_clr: assert property (p_software_reset_trigger_clr) else $error("soft reset left state behind");

  property p_software_reset_timeout_flag;
    sr_ff == SR_WAIT && !ok_s2_ff && tmr_ff == 8'(SOFTWARE_RESET_TIMEOUT_FLAG_CYC - 1) |=> to_ff && sr_ff == SR_IDLE;
  endproperty
  a_software_reset_timeout_flag: assert property (p_software_reset_timeout_flag) else $error("soft reset timeout not flagged");

  property p_full;
    used_ff >= thr |-> !rd_go ##1 !rxd_push;
  endproperty
  a_full: assert property (p_full) else $error("receive data pushed while full");

  property p_skip_hold;
    skip_ff && !(rxd_drain && rxd_drain_last) |=> skip_ff || $past(software_reset_trigger_go);
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("skip cleared early");

  property p_drop;
    overrun |=> (drop_ff == $past(drop_ff) + 16'h1 && ovr_ff) || $past(software_reset_trigger_go);
  endproperty
  a_drop: assert property (p_drop) else $error("lost frame not counted");

  property p_split;
    sr_ff == SR_IDLE && $stable(sz_ff) |=>
      rx_status_bytes + rx_data_bytes + tx_data_bytes + 16'(TXS_BYTES) == 16'(MEM_BYTES) || sz_ff != $past(sz_ff);
  endproperty
  a_split: assert property (p_split) else $error("memory split does not add up");

  property p_tx2;
    txf_ff == 2'(MIL_TX_FRAMES) |-> !tpop;
  endproperty
  a_tx2: assert property (p_tx2) else $error("third frame taken into side buffer");

  property p_mil_cap;
    rcnt_ff <= (MIL_RX_AW+1)'(MIL_RX_WORDS) && txw_ff <= 10'(MIL_TX_WORDS);
  endproperty
  a_mil_cap: assert property (p_mil_cap) else $error("side buffer over capacity");

  c_software_reset_trigger: cover property (sr_ff == SR_WAIT ##1 software_reset_trigger_go);
  c_to: cover property ($rose(to_ff));
  c_overrun: cover property (overrun);
  c_skip: cover property (skip_ff ##[1:50] !skip_ff);

endmodule : efa_alloc

// file: efa_far_model.sv
// Behavioural model of the receive data FIFO and the transmit data FIFO beyond the allocator.
module efa_far_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Receive data FIFO side
  input wire logic rxd_push,
  input wire logic rxd_wlast,
  input wire logic rxd_skip,
  input wire logic drain_en,
  output logic rxd_drain,
  output logic rxd_drain_last,
  // Transmit data FIFO side
  input wire logic txd_pop,
  output logic txd_valid,
  output logic txd_last,
  output int pop_cnt
);
  timeunit 1ns;
  timeprecision 1ns;

  logic q[$];
  logic hold_off;

  // ----------------------------------------
  // Receive data FIFO
  // ----------------------------------------
  // store, drain, skip.
  // One idle cycle after a skip ends on a last word, since the skip level drops one cycle late.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      q.delete();
      rxd_drain <= 1'b0;
      rxd_drain_last <= 1'b0;
      hold_off <= 1'b0;
    end else begin
      rxd_drain <= 1'b0;
      rxd_drain_last <= 1'b0;
      hold_off <= 1'b0;
      if (rxd_push) begin
        q.push_back(rxd_wlast);
      end
      if ((drain_en || (rxd_skip && !hold_off)) && q.size() > 0) begin
        rxd_drain <= 1'b1;
        rxd_drain_last <= q[0];
        if (q[0] && rxd_skip) begin
          hold_off <= 1'b1;
        end
        q.pop_front();
      end
    end
  end

  // ----------------------------------------
  // Transmit data FIFO
  // ----------------------------------------
  // Three-word frames: a command word and two payload words.
  assign txd_valid = 1'b1;
  assign txd_last = (pop_cnt % 3 == 2);
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pop_cnt <= 0;
    end else if (txd_pop) begin
      pop_cnt <= pop_cnt + 1;
    end
  end
endmodule : efa_far_model

// file: efa_alloc_test.sv
// Self-checking testbench of the packet buffer allocator.
module efa_alloc_test;
  import efa_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, phy_clk_ok = 1;
  logic mac_tx_err = 0, mac_rx_err = 0, mac_rx_valid = 0, mac_rx_last = 0;
  logic mac_tx_rd = 0, mac_tx_rd_last = 0, drain_en = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, mac_rx_data = 32'h0, reg_rdata, d, rxd_wdata, last_word = 32'h0;
  logic mac_csr_reset, rxd_push, rxd_wlast, rxd_drain, rxd_drain_last, rxd_skip;
  logic txd_valid, txd_last, txd_pop, mil_tx_avail;
  logic [15:0] tx_data_bytes, rx_data_bytes, rx_status_bytes;
  logic [1:0] keep_bits;
  int n_fail = 0, samples_checked = 0, pop_cnt, csr_pulses = 0;
  int txd, rxt, rxs;

  efa_alloc i_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phy_clk_ok(phy_clk_ok), .mac_tx_err(mac_tx_err),
    .mac_rx_err(mac_rx_err), .mac_csr_reset(mac_csr_reset), .mac_rx_valid(mac_rx_valid),
    .mac_rx_data(mac_rx_data), .mac_rx_last(mac_rx_last), .rxd_push(rxd_push), .rxd_wdata(rxd_wdata),
    .rxd_wlast(rxd_wlast), .rxd_drain(rxd_drain), .rxd_drain_last(rxd_drain_last), .rxd_skip(rxd_skip),
    .txd_valid(txd_valid), .txd_last(txd_last), .txd_pop(txd_pop), .mac_tx_rd(mac_tx_rd),
    .mac_tx_rd_last(mac_tx_rd_last), .mil_tx_avail(mil_tx_avail), .tx_data_bytes(tx_data_bytes),
    .rx_data_bytes(rx_data_bytes), .rx_status_bytes(rx_status_bytes), .keep_bits(keep_bits));

  efa_far_model i_far (.mclk(mclk), .rst(rst), .rxd_push(rxd_push), .rxd_wlast(rxd_wlast),
    .rxd_skip(rxd_skip), .drain_en(drain_en), .rxd_drain(rxd_drain), .rxd_drain_last(rxd_drain_last),
    .txd_pop(txd_pop), .txd_valid(txd_valid), .txd_last(txd_last), .pop_cnt(pop_cnt));

  initial begin
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (mac_csr_reset === 1'b1) begin
      csr_pulses <= csr_pulses + 1;
    end
  end

  // The last word handed to the receive data FIFO, to follow order through the side buffer.
  always @(posedge mclk) begin
    if (rxd_push === 1'b1) begin
      last_word <= rxd_wdata;
    end
  end

  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  // Bounded wait for a self-clearing bit.
  task automatic poll(input logic [7:0] a, input int b);
    int i;
    for (i = 0; i < 300; i++) begin
      rd(a, d);
      if (d[b] === 1'b0) break;
    end
    if (i == 300) begin
      n_fail++;
      report_and_stop();
    end
  endtask : poll

  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      mac_rx_valid <= 1'b1;
      mac_rx_data <= 32'(i);
      mac_rx_last <= (i == n - 1);
    end
    @(posedge mclk);
    mac_rx_valid <= 1'b0;
  endtask : send

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    wr(RXCTL_OFS - 8'h04, 32'h0017_0000);
    rd(8'h74, d); chk(d, 32'h0005_0000);
    rd(8'h7c, d); chk(d, 32'h0);
    // legal sizes only
    // Every legal transmit size, with the preserved bits and the must-be-one bit set.
    for (int sz = 2; sz <= 14; sz++) begin
      txd = sz * 1024 - 512;
      rxt = 16384 - sz * 1024;
      rxs = rxt / 16;
      wr(8'h74, 32'h3010_0000 | (sz << 16));
      rd(8'h74, d); chk(d, 32'h3010_0000 | (sz << 16));
      rd(8'h90, d); chk(d, {16'(rxt - rxs), 16'(txd)});
      rd(8'h94, d); chk(d, 32'(rxs));
      chk(32'(tx_data_bytes), 32'(txd));
    end
    chk(32'(keep_bits), 32'h3);
    // The MAC never reads, so the side buffer stops after two whole frames.
    chk(32'(pop_cnt), 32'd6);
    chk(32'(mil_tx_avail), 32'h1);
    // Size 14 leaves 1920 data bytes: full at 476 words, then 32 more wait in the side buffer.
    send(560);
    send(4);
    repeat (10) @(posedge mclk);
    chk(32'(i_far.q.size()), 32'd476);
    rd(8'h98, d); chk(d, 32'd2);
    drain_en <= 1'b1;
    repeat (600) @(posedge mclk);
    drain_en <= 1'b0;
    chk(32'(i_far.q.size()), 32'd0);
    chk(last_word, 32'd507);
    send(4);
    repeat (10) @(posedge mclk);
    rd(8'h98, d); chk(d, 32'd2);
    chk(last_word, 32'h3);
    // Empty the receive data FIFO, then skip over one whole frame of two queued frames.
    send(3);
    drain_en <= 1'b1;
    repeat (20) @(posedge mclk);
    drain_en <= 1'b0;
    chk(32'(i_far.q.size()), 32'd0);
    send(3);
    send(3);
    repeat (10) @(posedge mclk);
    wr(8'h78, 32'h8000_0000);
    #1;
    chk(32'(rxd_skip), 32'h1);
    poll(8'h78, 31);
    chk(32'(i_far.q.size()), 32'd3);
    wr(8'h78, 32'h0);
    repeat (5) @(posedge mclk);
    chk(32'(i_far.q.size()), 32'd3);
    // Latch both error flags, then a software reset with the PHY running.
    @(posedge mclk);
    mac_tx_err <= 1'b1;
    mac_rx_err <= 1'b1;
    @(posedge mclk);
    mac_tx_err <= 1'b0;
    mac_rx_err <= 1'b0;
    rd(8'h9c, d); chk(d, 32'h3);
    wr(8'h74, 32'h301e_0001);
    poll(8'h74, 0);
    chk(32'(csr_pulses), 32'd1);
    rd(8'h74, d); chk(d, 32'h3005_0000);
    rd(8'h9c, d); chk(d, 32'h0);
    rd(8'h98, d); chk(d, 32'h0);
    // PHY clocks stopped: the reset must give up and flag a timeout.
    phy_clk_ok <= 1'b0;
    wr(8'h74, 32'h3005_0001);
    poll(8'h74, 0);
    chk(d, 32'h3005_0002);
    chk(32'(csr_pulses), 32'd1);
    phy_clk_ok <= 1'b1;
    wr(8'h74, 32'h3005_0000);
    repeat (20) @(posedge mclk);
    chk(32'(csr_pulses), 32'd1);
    report_and_stop();
  end
endmodule : efa_alloc_test
